// >>> dv/crie_rx_irq_en_tb_top.sv
// Self-checking bench for the CAN receive interrupt enable block.
// Assumes the block's package is compiled first and one 100 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t %s got %0h exp %0h", $time, m, g, e); end end
module crie_rx_irq_en_tb_top;
    import crie_pkg::*;
    logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rdy_q;
    logic [31:0]      haddr, hwdata, hrdata, rd, rd_q;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [8:0]       tx_err_count;
    logic [7:0]       rx_err_count;
    logic             wake_function_enable;
    crie_evt_t        evt;
    crie_irq_t        irq;
    int               compares, miscompares, cyc;
    int               rl[6] = '{0, 96, 97, 127, 128, 255};
    int               tl[8] = '{0, 96, 97, 127, 128, 255, 256, 300};

    assign hready = hreadyout;
    crie_rx_irq_en u_crie_rx_irq_en (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .evt(evt), .tx_err_count(tx_err_count), .rx_err_count(rx_err_count), .irq(irq),
        .wake_function_enable(wake_function_enable));

    // ****************************************************************
    // Clock, edge capture and timeout
    // ****************************************************************
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Answers are captured at the edge so the bench never races the slave's flops.
    always @(posedge hclk) begin
        rd_q  <= hrdata;
        rdy_q <= hreadyout;
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    // ****************************************************************
    // Bus tasks and reference functions
    // ****************************************************************
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cw(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do cw(1); while (rdy_q !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do cw(1); while (rdy_q !== 1'b1);
        rd = rd_q;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h00_0000, d});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(rd, {24'h00_0000, e}, m)
    endtask
    task automatic pulse(input crie_evt_t e);
        evt <= e;
        cw(1);
        evt <= '0;
    endtask
    function automatic logic [1:0] st_tx(input int t);
        if (t > 255) return 2'd3;
        if (t > 127) return 2'd2;
        if (t > 96) return 2'd1;
        return 2'd0;
    endfunction
    function automatic logic [1:0] st_rx(input int r, input int t);
        return (t > 255) ? 2'd3 : st_tx(r);
    endfunction
    function automatic logic hit(input logic [1:0] s, input logic [1:0] o, input logic [1:0] n);
        if (o == n || s == 2'd0) return 1'b0;
        if (s == 2'd1) return (o == 2'd3) || (n == 2'd3);
        if (s == 2'd2) return (o >= 2'd2) || (n >= 2'd2);
        return 1'b1;
    endfunction

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [1:0] ro, to, rn, tn, sr, stx;
        logic [7:0] m, d;
        logic       ce, ef, en;
        int         r0, t0, r1, t1, k;
        {hsel, hwrite, htrans, haddr, hwdata, evt} = '0;
        hsize = 3'b010;
        tx_err_count = 9'h000;
        rx_err_count = 8'h00;
        hresetn = 1'b0;
        void'($urandom(32'h19bc));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        cw(2);
        rchk(CRIE_OFF_RIER, CRIE_RIER_RST, "reset value");
        rchk(CRIE_OFF_STATUS, 8'h00, "reset status");
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            wr(CRIE_OFF_RIER, d);
            rchk(CRIE_OFF_RIER, d, "enable readback");
        end
        wr(8'h10, 8'hFF);
        rchk(8'h10, 8'h00, "unmapped");
        `CHK(hresp, 1'b0, "response")
        wr(CRIE_OFF_CTRL, 8'h04);
        `CHK(wake_function_enable, 1'b1, "wake function")
        for (int i = 0; i < 12; i++) begin
            k = i % 3;
            en = ((i / 3) % 2) == 1;
            m = (k == 0) ? 8'h80 : (k == 1) ? 8'h02 : 8'h01;
            wr(CRIE_OFF_RIER, en ? m : 8'h00);
            pulse(crie_evt_t'(3'b100 >> k));
            cw(2);
            `CHK(irq, crie_irq_t'({k == 0 && en, k == 1 && en, k == 2 && en, en}), "irq")
            rchk(CRIE_OFF_STATUS, m, "event flag");
            wr(CRIE_OFF_CLEAR, m);
            cw(2);
            `CHK(irq, crie_irq_t'(4'h0), "irq cleared")
        end
        wr(CRIE_OFF_CTRL, 8'h00);
        `CHK(wake_function_enable, 1'b0, "wake function off")
        pulse(crie_evt_t'(3'b100));
        rchk(CRIE_OFF_STATUS, 8'h00, "wake without function");
        // Initialization mode: enables forced low, sensitivity kept, writes refused.
        wr(CRIE_OFF_RIER, 8'hFF);
        wr(CRIE_OFF_CTRL, 8'h01);
        cw(2);
        rchk(CRIE_OFF_CTRL, 8'h03, "init ack");
        rchk(CRIE_OFF_RIER, 8'h3C, "held in init");
        wr(CRIE_OFF_RIER, 8'h00);
        rchk(CRIE_OFF_RIER, 8'h3C, "write refused");
        pulse(crie_evt_t'(3'b010));
        cw(2);
        `CHK(irq.err, 1'b0, "masked in init")
        wr(CRIE_OFF_CTRL, 8'h00);
        cw(2);
        rchk(CRIE_OFF_RIER, 8'h3C, "after init");
        wr(CRIE_OFF_RIER, 8'h02);
        cw(2);
        `CHK(irq.err, 1'b1, "pending flag unmasked")
        for (int i = 0; i < 24; i++) begin
            r0 = rl[$urandom % 6];
            t0 = tl[$urandom % 8];
            rx_err_count <= 8'(r0);
            tx_err_count <= 9'(t0);
            wr(CRIE_OFF_RIER, 8'h00);
            wr(CRIE_OFF_CLEAR, 8'hC3);
            cw(3);
            ro = st_rx(r0, t0);
            to = st_tx(t0);
            rchk(CRIE_OFF_STATUS, {2'b00, ro, to, 2'b00}, "settled");
            sr = 2'($urandom);
            stx = 2'($urandom);
            ce = 1'($urandom);
            if (i < 4) begin
                sr = 2'(i);
                stx = 2'(3 - i);
            end
            wr(CRIE_OFF_RIER, {1'b0, ce, sr, stx, 2'b00});
            r1 = rl[$urandom % 6];
            t1 = tl[$urandom % 8];
            // Leaving bus-off skips the receiver to OK, so keep its counter low there.
            if (t0 > 255 && t1 <= 255) r1 = 0;
            rx_err_count <= 8'(r1);
            tx_err_count <= 9'(t1);
            cw(3);
            rn = st_rx(r1, t1);
            tn = st_tx(t1);
            ef = hit(sr, ro, rn) | hit(stx, to, tn);
            rchk(CRIE_OFF_STATUS, {1'b0, ef, rn, tn, 2'b00}, "change");
            `CHK(irq.err, ef & ce, "status irq")
            if (ef) begin
                rx_err_count <= 8'(rl[$urandom % 6]);
                tx_err_count <= 9'(tl[$urandom % 8]);
                cw(3);
                rchk(CRIE_OFF_STATUS, {1'b0, ef, rn, tn, 2'b00}, "frozen");
            end
        end
        end_sim();
    end
endmodule

// >>> inc/crie_pkg.sv
// Constants and types for the CAN receive interrupt enable block.
// Assumes a single 100 MHz bus clock and a 32-bit AHB-Lite register bus.
package crie_pkg;

    // ****************************************************************
    // Register map and field layout
    // ****************************************************************
    localparam int         CRIE_AW         = 8;
    localparam logic [7:0] CRIE_OFF_RIER   = 8'h00;
    localparam logic [7:0] CRIE_OFF_STATUS = 8'h04;
    localparam logic [7:0] CRIE_OFF_CLEAR  = 8'h08;
    localparam logic [7:0] CRIE_OFF_CTRL   = 8'h0C;

    localparam int CRIE_B_WAKE = 7;
    localparam int CRIE_B_CSC  = 6;
    localparam int CRIE_B_RXS  = 4;
    localparam int CRIE_B_TXS  = 2;
    localparam int CRIE_B_OVR  = 1;
    localparam int CRIE_B_RXF  = 0;

    localparam int CRIE_B_INIT_REQUEST = 0;
    localparam int CRIE_B_INIT_ACKNOWLEDGE = 1;
    localparam int CRIE_B_WAKE_FUNCTION_ENABLE   = 2;

    localparam logic [7:0] CRIE_RIER_RST   = 8'h00;
    localparam logic [7:0] CRIE_FLAG_MASK  = 8'hC3;
    localparam logic [7:0] CRIE_SENS_MASK  = 8'h3C;

    // ****************************************************************
    // Error counter thresholds and sensitivity codes
    // ****************************************************************
    localparam logic [7:0] CRIE_OK_MAX  = 8'h60;
    localparam logic [7:0] CRIE_WRN_MAX = 8'h7F;
    localparam logic [8:0] CRIE_ACT_MAX = 9'h0FF;

    localparam logic [1:0] CRIE_SENS_NONE = 2'h0;
    localparam logic [1:0] CRIE_SENS_BOFF = 2'h1;
    localparam logic [1:0] CRIE_SENS_ERR  = 2'h2;
    localparam logic [1:0] CRIE_SENS_ALL  = 2'h3;

    typedef enum logic [1:0] {
        CRIE_ST_OK,
        CRIE_ST_WRN,
        CRIE_ST_ERR,
        CRIE_ST_BOFF
    } crie_bus_state_t;

    typedef struct packed {
        logic wake;
        logic overrun;
        logic rx_full;
    } crie_evt_t;

    typedef struct packed {
        logic wake;
        logic err;
        logic rx;
        logic any;
    } crie_irq_t;

    typedef struct packed {
        logic                 valid;
        logic                 write;
        logic [CRIE_AW-1:0]   addr;
    } crie_aph_t;

endpackage

// >>> rtl/crie_rx_irq_en.sv
// Receive interrupt enable logic of a CAN controller with an AHB-Lite slave.
// Assumes events, error counters and the bus all run on hclk.
`timescale 1ns/1ps
module crie_rx_irq_en
    import crie_pkg::*;
(
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire crie_pkg::crie_evt_t       evt,
    input  wire logic [8:0]                tx_err_count,
    input  wire logic [7:0]                rx_err_count,
    output crie_pkg::crie_irq_t            irq,
    output logic                           wake_function_enable
);
    import crie_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    crie_aph_t       aph_r,     aph_nxt;
    logic [31:0]     hrdata_r,  hrdata_nxt;
    logic [7:0]      rier_r,    rier_nxt;
    logic [7:0]      flag_r,    flag_nxt;
    crie_bus_state_t rx_st_r,   rx_st_nxt;
    crie_bus_state_t tx_st_r,   tx_st_nxt;
    logic            init_rq_r, init_rq_nxt;
    logic            init_ak_r;
    logic            wake_function_enable_r,    wake_function_enable_nxt;
    crie_irq_t       irq_r,     irq_nxt;

    logic            init_mode;
    logic            not_init;
    logic            wr_rier;
    logic            wr_clear;
    logic            wr_ctrl;
    logic [7:0]      status_v;
    crie_bus_state_t rx_calc;
    crie_bus_state_t tx_calc;
    logic            csc_set;

    assign init_mode = init_rq_r & init_ak_r;
    assign not_init  = ~init_rq_r & ~init_ak_r;
    assign status_v  = {flag_r[CRIE_B_WAKE], flag_r[CRIE_B_CSC], rx_st_r, tx_st_r,
                        flag_r[CRIE_B_OVR], flag_r[CRIE_B_RXF]};

    // A sensitivity code decides whether one old-to-new move counts.
    function automatic logic sens_hit(input logic [1:0] sens,
                                      input crie_bus_state_t o,
                                      input crie_bus_state_t n);
        logic hit;
        hit = 1'b0;
        case (sens)
            CRIE_SENS_BOFF: hit = (o != n) && (o == CRIE_ST_BOFF || n == CRIE_ST_BOFF);
            CRIE_SENS_ERR:  hit = (o != n) && (o >= CRIE_ST_ERR || n >= CRIE_ST_ERR);
            CRIE_SENS_ALL:  hit = (o != n);
            default:        hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    // Zero wait states: read data is sampled in the address phase so that
    // hrdata can come straight from a flop in the data phase.
    always_comb begin
        aph_nxt       = aph_r;
        aph_nxt.valid = hsel & htrans[1] & hready;
        aph_nxt.write = hwrite;
        aph_nxt.addr  = haddr[CRIE_AW-1:0];
        hrdata_nxt    = 32'h0000_0000;
        if (hsel & htrans[1] & hready & ~hwrite) begin
            if (haddr[CRIE_AW-1:0] == CRIE_OFF_RIER) begin
                hrdata_nxt[7:0] = rier_r;
            end else if (haddr[CRIE_AW-1:0] == CRIE_OFF_STATUS) begin
                hrdata_nxt[7:0] = status_v;
            end else if (haddr[CRIE_AW-1:0] == CRIE_OFF_CTRL) begin
                hrdata_nxt[CRIE_B_INIT_REQUEST] = init_rq_r;
                hrdata_nxt[CRIE_B_INIT_ACKNOWLEDGE] = init_ak_r;
                hrdata_nxt[CRIE_B_WAKE_FUNCTION_ENABLE]   = wake_function_enable_r;
            end
        end
    end

    assign wr_rier  = aph_r.valid & aph_r.write & (aph_r.addr == CRIE_OFF_RIER);
    assign wr_clear = aph_r.valid & aph_r.write & (aph_r.addr == CRIE_OFF_CLEAR);
    assign wr_ctrl  = aph_r.valid & aph_r.write & (aph_r.addr == CRIE_OFF_CTRL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_r     <= '0;
            hrdata_r  <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            aph_r     <= aph_nxt;
            hrdata_r  <= hrdata_nxt;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata = hrdata_r;

    // ****************************************************************
    // Control and enable registers
    // ****************************************************************
    always_comb begin
        init_rq_nxt = init_rq_r;
        wake_function_enable_nxt    = wake_function_enable_r;
        rier_nxt    = rier_r;
        if (wr_ctrl) begin
            init_rq_nxt = hwdata[CRIE_B_INIT_REQUEST];
            wake_function_enable_nxt    = hwdata[CRIE_B_WAKE_FUNCTION_ENABLE];
        end
        if (wr_rier && not_init) begin
            rier_nxt = hwdata[7:0];
        end
        if (init_mode) begin
            // Only the enable bits go back to reset; sensitivities are kept.
            rier_nxt = (rier_nxt & CRIE_SENS_MASK) | (CRIE_RIER_RST & ~CRIE_SENS_MASK);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_rq_r <= 1'b0;
            init_ak_r <= 1'b0;
            wake_function_enable_r    <= 1'b0;
            rier_r    <= CRIE_RIER_RST;
        end else begin
            init_rq_r <= init_rq_nxt;
            init_ak_r <= init_rq_r;
            wake_function_enable_r    <= wake_function_enable_nxt;
            rier_r    <= rier_nxt;
        end
    end

    assign wake_function_enable = wake_function_enable_r;

    // ****************************************************************
    // Bus state, flags and interrupt requests
    // ****************************************************************
    always_comb begin
        if (tx_err_count > CRIE_ACT_MAX) begin
            tx_calc = CRIE_ST_BOFF;
        end else if (tx_err_count > {1'b0, CRIE_WRN_MAX}) begin
            tx_calc = CRIE_ST_ERR;
        end else if (tx_err_count > {1'b0, CRIE_OK_MAX}) begin
            tx_calc = CRIE_ST_WRN;
        end else begin
            tx_calc = CRIE_ST_OK;
        end
        if (tx_calc == CRIE_ST_BOFF) begin
            rx_calc = CRIE_ST_BOFF;
        end else if (rx_st_r == CRIE_ST_BOFF) begin
            rx_calc = CRIE_ST_OK;
        end else if (rx_err_count > CRIE_WRN_MAX) begin
            rx_calc = CRIE_ST_ERR;
        end else if (rx_err_count > CRIE_OK_MAX) begin
            rx_calc = CRIE_ST_WRN;
        end else begin
            rx_calc = CRIE_ST_OK;
        end
    end

    always_comb begin
        rx_st_nxt = rx_st_r;
        tx_st_nxt = tx_st_r;
        csc_set   = 1'b0;
        // A pending change freezes the reported states so software reads
        // the state that caused the interrupt.
        if (!flag_r[CRIE_B_CSC]) begin
            rx_st_nxt = rx_calc;
            tx_st_nxt = tx_calc;
            csc_set   = sens_hit(rier_r[CRIE_B_RXS +: 2], rx_st_r, rx_calc)
                      | sens_hit(rier_r[CRIE_B_TXS +: 2], tx_st_r, tx_calc);
        end
        // Set wins over a clear written in the same cycle.
        flag_nxt = flag_r & CRIE_FLAG_MASK;
        if (wr_clear) begin
            flag_nxt = flag_nxt & ~hwdata[7:0];
        end
        flag_nxt[CRIE_B_WAKE] = flag_nxt[CRIE_B_WAKE] | (evt.wake & wake_function_enable_r);
        flag_nxt[CRIE_B_CSC]  = flag_nxt[CRIE_B_CSC] | csc_set;
        flag_nxt[CRIE_B_OVR]  = flag_nxt[CRIE_B_OVR] | evt.overrun;
        flag_nxt[CRIE_B_RXF]  = flag_nxt[CRIE_B_RXF] | evt.rx_full;
        irq_nxt.wake = flag_nxt[CRIE_B_WAKE] & rier_nxt[CRIE_B_WAKE];
        irq_nxt.err  = (flag_nxt[CRIE_B_CSC] & rier_nxt[CRIE_B_CSC])
                     | (flag_nxt[CRIE_B_OVR] & rier_nxt[CRIE_B_OVR]);
        irq_nxt.rx   = flag_nxt[CRIE_B_RXF] & rier_nxt[CRIE_B_RXF];
        irq_nxt.any  = irq_nxt.wake | irq_nxt.err | irq_nxt.rx;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_st_r <= CRIE_ST_OK;
            tx_st_r <= CRIE_ST_OK;
            flag_r  <= 8'h00;
            irq_r   <= '0;
        end else begin
            rx_st_r <= rx_st_nxt;
            tx_st_r <= tx_st_nxt;
            flag_r  <= flag_nxt;
            irq_r   <= irq_nxt;
        end
    end

    assign irq = irq_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_wr_blocked;
        @(posedge hclk) disable iff (!hresetn)
        (wr_rier && !not_init && !init_mode) |=> $stable(rier_r);
    endproperty
    a_wr_blocked: assert property (p_wr_blocked) else $error("enable write taken in init");

    property p_init_hold;
        @(posedge hclk) disable iff (!hresetn)
        init_mode |=> (rier_r & ~CRIE_SENS_MASK) == (CRIE_RIER_RST & ~CRIE_SENS_MASK);
    endproperty
    a_init_hold: assert property (p_init_hold) else $error("enables not held in init");

    property p_sens_kept;
        @(posedge hclk) disable iff (!hresetn)
        (init_mode && !wr_rier) |=> (rier_r & CRIE_SENS_MASK) == $past(rier_r & CRIE_SENS_MASK);
    endproperty
    a_sens_kept: assert property (p_sens_kept) else $error("sensitivity lost in init");

    property p_wake;
        @(posedge hclk) disable iff (!hresetn)
        (evt.wake && wake_function_enable_r && rier_r[CRIE_B_WAKE] && !init_mode) |=> irq.wake;
    endproperty
    a_wake: assert property (p_wake) else $error("wake event gave no request");

    // The request flop loads at the same edge as the flag and enable flops, so a
    // masked status change with no overrun flag must show no error request now.
    property p_csc_off;
        @(posedge hclk) disable iff (!hresetn)
        (rier_r[CRIE_B_CSC +: 1] == 1'b0 && !flag_r[CRIE_B_OVR]) |-> !irq.err;
    endproperty
    a_csc_off: assert property (p_csc_off) else $error("error request while masked");

    property p_rx_freeze;
        @(posedge hclk) disable iff (!hresetn)
        flag_r[CRIE_B_CSC] |=> $stable(rx_st_r) && $stable(tx_st_r);
    endproperty
    a_rx_freeze: assert property (p_rx_freeze) else $error("state moved while pending");

    property p_rx_track;
        @(posedge hclk) disable iff (!hresetn)
        !flag_r[CRIE_B_CSC] && tx_err_count > CRIE_ACT_MAX |=> tx_st_r == CRIE_ST_BOFF
                                                             && rx_st_r == CRIE_ST_BOFF;
    endproperty
    a_rx_track: assert property (p_rx_track) else $error("bus-off not reported");

    property p_ovr;
        @(posedge hclk) disable iff (!hresetn)
        (evt.overrun && rier_r[CRIE_B_OVR] && !init_mode) ##1 !init_mode |=> irq.err;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun gave no error request");

    property p_rxf;
        @(posedge hclk) disable iff (!hresetn)
        (evt.rx_full && rier_r[CRIE_B_RXF] && !init_mode) ##1 !init_mode |=> irq.rx;
    endproperty
    a_rxf: assert property (p_rxf) else $error("receive full gave no request");

    property p_pending;
        @(posedge hclk) disable iff (!hresetn)
        irq.rx |-> flag_r[CRIE_B_RXF] && rier_r[CRIE_B_RXF];
    endproperty
    a_pending: assert property (p_pending) else $error("receive request without cause");

    property p_any;
        @(posedge hclk) disable iff (!hresetn)
        irq.any == (irq.wake | irq.err | irq.rx);
    endproperty
    a_any: assert property (p_any) else $error("summary request mismatch");

    c_csc:  cover property (@(posedge hclk) disable iff (!hresetn) $rose(flag_r[CRIE_B_CSC]));
    c_boff: cover property (@(posedge hclk) disable iff (!hresetn) tx_st_r == CRIE_ST_BOFF);
    c_err:  cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq.err));
    c_wr:   cover property (@(posedge hclk) disable iff (!hresetn) wr_rier && not_init);

endmodule
